/* hw/blk_bus_if.sv */
// Bus carrier joining the master end and the slave end
`timescale 1ns/100ps
interface blk_bus_if #(
  parameter int ADR_W = blk_bus_pkg::ADR_W_DEF,
  parameter int DAT_W = blk_bus_pkg::DAT_W_DEF,
  parameter int TAG_W = blk_bus_pkg::TAG_W_DEF
);
  localparam int SEL_W = DAT_W / blk_bus_pkg::LANE_W;

  logic             cyc;
  logic             stb;
  logic             lock;
  logic             we;
  logic [ADR_W-1:0] adr;
  logic [TAG_W-1:0] tga;
  logic [SEL_W-1:0] sel;
  logic [1:0]       tgc;
  logic [DAT_W-1:0] dat_w;
  logic [TAG_W-1:0] tgd_w;
  logic [DAT_W-1:0] dat_r;
  logic [TAG_W-1:0] tgd_r;
  logic             ack;

  modport master (
    output cyc, stb, lock, we, adr, tga, sel, tgc, dat_w, tgd_w,
    input  dat_r, tgd_r, ack
  );

  modport slave (
    input  cyc, stb, lock, we, adr, tga, sel, tgc, dat_w, tgd_w,
    output dat_r, tgd_r, ack
  );
endinterface

/* hw/blk_bus_master.sv */
// Master end: runs single, block and RMW cycles from user commands
`timescale 1ns/100ps
module blk_bus_master #(
  parameter int ADR_W = blk_bus_pkg::ADR_W_DEF,
  parameter int DAT_W = blk_bus_pkg::DAT_W_DEF,
  parameter int TAG_W = blk_bus_pkg::TAG_W_DEF,
  parameter int LEN_W = blk_bus_pkg::LEN_W_DEF
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  // Bus
  blk_bus_if.master             bus,
  // Command
  input  wire logic             cmd_valid_i,
  input  blk_bus_pkg::op_t      cmd_op_i,
  input  wire logic [LEN_W-1:0] cmd_len_i,
  input  wire logic [ADR_W-1:0] cmd_addr_i,
  input  wire logic [TAG_W-1:0] cmd_tga_i,
  input  wire logic [DAT_W/blk_bus_pkg::LANE_W-1:0] cmd_sel_i,
  input  wire logic             cmd_lock_i,
  output logic                  cmd_ready_o,
  // Read pacing and write data
  input  wire logic             pause_i,
  input  wire logic             wr_valid_i,
  input  wire logic [DAT_W-1:0] wr_data_i,
  input  wire logic [TAG_W-1:0] wr_tgd_i,
  input  wire logic [DAT_W/blk_bus_pkg::LANE_W-1:0] wr_sel_i,
  output logic                  wr_ready_o,
  // Results
  output logic                  rd_valid_o,
  output logic [DAT_W-1:0]      rd_data_o,
  output logic [TAG_W-1:0]      rd_tgd_o,
  output logic                  done_o,
  output logic                  busy_o
);
  localparam int SEL_W = DAT_W / blk_bus_pkg::LANE_W;

  // ==========================================================================
  // Parameter check
  if (DAT_W % blk_bus_pkg::LANE_W != 0 || SEL_W < 1 || LEN_W < 1 ||
      ADR_W < 2) begin : g_bad
    $error("blk_bus_master: unsupported widths");
  end

  // ==========================================================================
  // State
  blk_bus_pkg::mst_state_t state_ff, nxt_state;
  logic             cyc_ff, nxt_cyc;
  logic             stb_ff, nxt_stb;
  logic             lock_ff, nxt_lock;
  logic             we_ff, nxt_we;
  logic             rmw_ff, nxt_rmw;
  logic [ADR_W-1:0] adr_ff, nxt_adr;
  logic [TAG_W-1:0] tga_ff, nxt_tga;
  logic [SEL_W-1:0] sel_ff, nxt_sel;
  logic [SEL_W-1:0] rsel_ff, nxt_rsel;
  logic [1:0]       tgc_ff, nxt_tgc;
  logic [DAT_W-1:0] dat_ff, nxt_dat;
  logic [TAG_W-1:0] tgd_ff, nxt_tgd;
  logic [LEN_W-1:0] left_ff, nxt_left;
  logic             rdv_ff, nxt_rdv;
  logic [DAT_W-1:0] rdd_ff, nxt_rdd;
  logic [TAG_W-1:0] rdt_ff, nxt_rdt;
  logic             done_ff, nxt_done;
  logic             xfer;
  logic             cont;
  logic             take_wr;

  assign xfer = cyc_ff & stb_ff & bus.ack;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_cyc   = cyc_ff;
    nxt_stb   = stb_ff;
    nxt_lock  = lock_ff;
    nxt_we    = we_ff;
    nxt_rmw   = rmw_ff;
    nxt_adr   = adr_ff;
    nxt_tga   = tga_ff;
    nxt_sel   = sel_ff;
    nxt_rsel  = rsel_ff;
    nxt_tgc   = tgc_ff;
    nxt_dat   = dat_ff;
    nxt_tgd   = tgd_ff;
    nxt_left  = left_ff;
    nxt_rdv   = 1'b0;
    nxt_rdd   = rdd_ff;
    nxt_rdt   = rdt_ff;
    nxt_done  = 1'b0;
    cont      = 1'b0;
    take_wr   = 1'b0;
    case (state_ff)
      blk_bus_pkg::M_IDLE: begin
        if (cmd_valid_i) begin
          // Cycle and its tag rise with or before the first strobe
          nxt_cyc  = 1'b1;
          nxt_lock = cmd_lock_i;
          nxt_adr  = cmd_addr_i;
          nxt_tga  = cmd_tga_i;
          nxt_rsel = cmd_sel_i;
          nxt_sel  = cmd_sel_i;
          nxt_rmw  = (cmd_op_i == blk_bus_pkg::OP_RMW);
          nxt_we   = (cmd_op_i == blk_bus_pkg::OP_WRITE);
          // A length of zero runs as one phase
          nxt_left = (nxt_rmw || cmd_len_i == '0) ? '0 :
                     LEN_W'(cmd_len_i - LEN_W'(1));
          if (nxt_rmw) begin
            nxt_tgc = blk_bus_pkg::CK_RMW;
          end else if (nxt_left == '0) begin
            nxt_tgc = blk_bus_pkg::CK_SINGLE;
          end else begin
            nxt_tgc = blk_bus_pkg::CK_BLOCK;
          end
          cont = 1'b1;
        end
      end
      blk_bus_pkg::M_PHASE: begin
        if (xfer) begin
          if (!we_ff) begin
            nxt_rdv = 1'b1;
            nxt_rdd = bus.dat_r;
            nxt_rdt = bus.tgd_r;
          end
          if (left_ff == '0 && !(rmw_ff && !we_ff)) begin
            // End on the edge of the final acknowledge
            nxt_cyc   = 1'b0;
            nxt_stb   = 1'b0;
            nxt_lock  = 1'b0;
            nxt_we    = 1'b0;
            nxt_tgc   = blk_bus_pkg::CK_NONE;
            nxt_done  = 1'b1;
            nxt_state = blk_bus_pkg::M_IDLE;
          end else if (rmw_ff && !we_ff) begin
            // Read half done: forced gap, then the write half
            nxt_we    = 1'b1;
            nxt_stb   = 1'b0;
            nxt_state = blk_bus_pkg::M_GAP;
          end else begin
            nxt_left = LEN_W'(left_ff - LEN_W'(1));
            nxt_adr  = ADR_W'(adr_ff + ADR_W'(SEL_W));
            cont     = 1'b1;
          end
        end
        // Without ack everything stands: slave wait state
      end
      blk_bus_pkg::M_GAP: begin
        cont = 1'b1;
      end
      default: begin
        nxt_state = blk_bus_pkg::M_IDLE;
        nxt_cyc   = 1'b0;
        nxt_stb   = 1'b0;
      end
    endcase
    // Launch the next phase now, or hold a master wait state
    if (cont) begin
      if (nxt_we ? wr_valid_i : !pause_i) begin
        nxt_stb   = 1'b1;
        nxt_state = blk_bus_pkg::M_PHASE;
        if (nxt_we) begin
          take_wr = 1'b1;
          nxt_dat = wr_data_i;
          nxt_tgd = wr_tgd_i;
          nxt_sel = wr_sel_i;
        end else begin
          nxt_sel = rsel_ff;
          if (state_ff == blk_bus_pkg::M_IDLE) begin
            nxt_sel = cmd_sel_i;
          end
        end
      end else begin
        nxt_stb   = 1'b0;
        nxt_state = blk_bus_pkg::M_GAP;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= blk_bus_pkg::M_IDLE;
      cyc_ff   <= 1'b0;
      stb_ff   <= 1'b0;
      lock_ff  <= 1'b0;
      we_ff    <= 1'b0;
      rmw_ff   <= 1'b0;
      adr_ff   <= '0;
      tga_ff   <= '0;
      sel_ff   <= '0;
      rsel_ff  <= '0;
      tgc_ff   <= blk_bus_pkg::CK_NONE;
      dat_ff   <= '0;
      tgd_ff   <= '0;
      left_ff  <= '0;
      rdv_ff   <= 1'b0;
      rdd_ff   <= '0;
      rdt_ff   <= '0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff   <= nxt_cyc;
      stb_ff   <= nxt_stb;
      lock_ff  <= nxt_lock;
      we_ff    <= nxt_we;
      rmw_ff   <= nxt_rmw;
      adr_ff   <= nxt_adr;
      tga_ff   <= nxt_tga;
      sel_ff   <= nxt_sel;
      rsel_ff  <= nxt_rsel;
      tgc_ff   <= nxt_tgc;
      dat_ff   <= nxt_dat;
      tgd_ff   <= nxt_tgd;
      left_ff  <= nxt_left;
      rdv_ff   <= nxt_rdv;
      rdd_ff   <= nxt_rdd;
      rdt_ff   <= nxt_rdt;
      done_ff  <= nxt_done;
    end
  end

  // ==========================================================================
  // Outputs; address and data only qualified by the strobe
  assign bus.cyc   = cyc_ff;
  assign bus.stb   = stb_ff;
  assign bus.lock  = lock_ff;
  assign bus.we    = we_ff;
  assign bus.adr   = adr_ff;
  assign bus.tga   = tga_ff;
  assign bus.sel   = sel_ff;
  assign bus.tgc   = tgc_ff;
  assign bus.dat_w = dat_ff;
  assign bus.tgd_w = tgd_ff;

  assign cmd_ready_o = (state_ff == blk_bus_pkg::M_IDLE);
  assign wr_ready_o  = take_wr;
  assign rd_valid_o  = rdv_ff;
  assign rd_data_o   = rdd_ff;
  assign rd_tgd_o    = rdt_ff;
  assign done_o      = done_ff;
  assign busy_o      = cyc_ff;

endmodule // blk_bus_master

/* hw/blk_bus_pkg.sv */
// Shared types and constants for the block/RMW bus master and slave ends
package blk_bus_pkg;

  // ==========================================================================
  // Default widths
  localparam int ADR_W_DEF = 32;
  localparam int DAT_W_DEF = 32;
  localparam int TAG_W_DEF = 4;
  localparam int LEN_W_DEF = 8;
  localparam int MEM_DEPTH_DEF = 64;
  localparam int LANE_W = 8;

  // ==========================================================================
  // Cycle type tag carried on tgc
  localparam logic [1:0] CK_NONE   = 2'h0;
  localparam logic [1:0] CK_SINGLE = 2'h1;
  localparam logic [1:0] CK_BLOCK  = 2'h2;
  localparam logic [1:0] CK_RMW    = 2'h3;

  // ==========================================================================
  // User command of the master end
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_RMW   = 2'h2
  } op_t;

  // ==========================================================================
  // State machines, Gray along the usual path
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_PHASE = 2'b01,
    M_GAP   = 2'b11
  } mst_state_t;

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_OPEN   = 2'b01,
    S_RMW_WR = 2'b11
  } slv_state_t;

endpackage

/* hw/blk_bus_slave.sv */
// Slave end: word memory answering single, block and RMW cycles
`timescale 1ns/100ps
module blk_bus_slave #(
  parameter int ADR_W = blk_bus_pkg::ADR_W_DEF,
  parameter int DAT_W = blk_bus_pkg::DAT_W_DEF,
  parameter int TAG_W = blk_bus_pkg::TAG_W_DEF,
  parameter int DEPTH = blk_bus_pkg::MEM_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  // Bus
  blk_bus_if.slave              bus,
  // User side
  input  wire logic             stall_i,
  output logic                  lock_held_o,
  output logic [1:0]            cycle_kind_o,
  output logic                  rmw_done_o,
  output logic                  rmw_abort_o
);
  localparam int SEL_W = DAT_W / blk_bus_pkg::LANE_W;
  localparam int AL    = $clog2(SEL_W);
  localparam int IDX_W = $clog2(DEPTH);

  // ==========================================================================
  // Parameter check
  if (DAT_W % blk_bus_pkg::LANE_W != 0 || SEL_W < 2 || DEPTH < 2 ||
      (1 << IDX_W) != DEPTH || ADR_W < IDX_W + AL) begin : g_bad
    $error("blk_bus_slave: unsupported width or depth");
  end

  // ==========================================================================
  // Handshake
  logic             xfer;
  logic [IDX_W-1:0] idx;
  logic [TAG_W-1:0] tag_ff;

  // Combinational ack lets a block run one phase per clock
  assign bus.ack = bus.cyc & bus.stb & ~stall_i;
  assign xfer    = bus.cyc & bus.stb & bus.ack;
  assign idx     = bus.adr[AL +: IDX_W];
  assign bus.tgd_r = tag_ff;

  // ==========================================================================
  // Storage, one generate lane per byte select
  for (genvar l = 0; l < SEL_W; l++) begin : g_lane
    // One array per lane, so every lane has a single writing process
    logic [blk_bus_pkg::LANE_W-1:0] lane_mem [DEPTH];

    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        for (int i = 0; i < DEPTH; i++) begin
          lane_mem[i] <= '0;
        end
      end else if (xfer && bus.we && bus.sel[l]) begin
        lane_mem[idx] <=
          bus.dat_w[l*blk_bus_pkg::LANE_W +: blk_bus_pkg::LANE_W];
      end
    end

    // Read data valid whenever ack is, straight from the storage flops
    assign bus.dat_r[l*blk_bus_pkg::LANE_W +: blk_bus_pkg::LANE_W] =
      lane_mem[idx];
  end

  logic [TAG_W-1:0] nxt_tag;
  always_comb begin
    nxt_tag = tag_ff;
    if (xfer && bus.we) begin
      nxt_tag = bus.tgd_w;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tag_ff <= '0;
    end else begin
      tag_ff <= nxt_tag;
    end
  end

  // ==========================================================================
  // Cycle tracking
  blk_bus_pkg::slv_state_t state_ff, nxt_state;
  logic       lock_ff, nxt_lock;
  logic [1:0] kind_ff, nxt_kind;
  logic       done_ff, nxt_done;
  logic       abort_ff, nxt_abort;

  always_comb begin
    nxt_state = state_ff;
    nxt_lock  = lock_ff;
    nxt_kind  = kind_ff;
    nxt_done  = 1'b0;
    nxt_abort = 1'b0;
    case (state_ff)
      blk_bus_pkg::S_IDLE: begin
        if (bus.cyc) begin
          nxt_state = blk_bus_pkg::S_OPEN;
          nxt_lock  = bus.lock;
          nxt_kind  = bus.tgc;
          // Read half may complete in the very first cycle
          if (xfer && !bus.we && bus.tgc == blk_bus_pkg::CK_RMW) begin
            nxt_state = blk_bus_pkg::S_RMW_WR;
          end
        end
      end
      blk_bus_pkg::S_OPEN: begin
        nxt_lock = bus.lock;
        if (!bus.cyc) begin
          nxt_state = blk_bus_pkg::S_IDLE;
          nxt_lock  = 1'b0;
          nxt_kind  = blk_bus_pkg::CK_NONE;
        end else if (xfer && !bus.we &&
                     kind_ff == blk_bus_pkg::CK_RMW) begin
          nxt_state = blk_bus_pkg::S_RMW_WR;
        end
      end
      blk_bus_pkg::S_RMW_WR: begin
        if (xfer && bus.we) begin
          // Leave here so the cycle end is not taken for an abort
          nxt_done  = 1'b1;
          nxt_state = blk_bus_pkg::S_OPEN;
        end else if (!bus.cyc) begin
          // Cycle dropped before its write half: report it
          nxt_abort = 1'b1;
          nxt_state = blk_bus_pkg::S_IDLE;
          nxt_lock  = 1'b0;
          nxt_kind  = blk_bus_pkg::CK_NONE;
        end
      end
      default: begin
        nxt_state = blk_bus_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= blk_bus_pkg::S_IDLE;
      lock_ff  <= 1'b0;
      kind_ff  <= blk_bus_pkg::CK_NONE;
      done_ff  <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lock_ff  <= nxt_lock;
      kind_ff  <= nxt_kind;
      done_ff  <= nxt_done;
      abort_ff <= nxt_abort;
    end
  end

  assign lock_held_o  = lock_ff;
  assign cycle_kind_o = kind_ff;
  assign rmw_done_o   = done_ff;
  assign rmw_abort_o  = abort_ff;

endmodule // blk_bus_slave

/* tb/blk_bus_asserts.sv */
// Concurrent checks on the bus joining the master end and the slave end
`timescale 1ns/100ps
module blk_bus_asserts #(
  parameter int ADR_W = blk_bus_pkg::ADR_W_DEF,
  parameter int DAT_W = blk_bus_pkg::DAT_W_DEF
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  // Bus
  input  wire logic             cyc,
  input  wire logic             stb,
  input  wire logic             lock,
  input  wire logic             we,
  input  wire logic [ADR_W-1:0] adr,
  input  wire logic [1:0]       tgc,
  input  wire logic             ack
);
  localparam int SEL_W = DAT_W / blk_bus_pkg::LANE_W;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  // ==========================================================================
  // Handshake
  chk_ack_needs_stb: assert property (ack |-> cyc && stb)
    else $error("ack seen without strobe and cycle");
  chk_stb_in_cyc: assert property (stb |-> cyc)
    else $error("strobe seen outside a cycle");
  chk_stall_holds: assert property (
    stb && !ack |=> stb && $stable(adr) && $stable(we))
    else $error("phase changed before its acknowledge");
  chk_lock_steady: assert property (
    cyc && $past(cyc) |-> $stable(lock) && $stable(tgc))
    else $error("lock or cycle tag moved inside a cycle");
  chk_last_drop: assert property ($fell(cyc) |-> $past(ack))
    else $error("cycle ended without a final acknowledge");

  // ==========================================================================
  // Block and read-modify-write sequencing
  chk_block_step: assert property (
    stb && ack && tgc == blk_bus_pkg::CK_BLOCK ##1 stb
      |-> adr == $past(adr) + SEL_W)
    else $error("next block phase not at the following word");
  chk_rmw_gap: assert property (
    stb && ack && !we && tgc == blk_bus_pkg::CK_RMW |=> cyc && !stb && we)
    else $error("read half not followed by a write gap");
  chk_rmw_end: assert property (
    stb && ack && we && tgc == blk_bus_pkg::CK_RMW |=> !cyc && !stb && !lock)
    else $error("cycle kept open after the write half");

  cover property (stb && ack ##1 stb && ack);
  cover property (stb && !ack ##1 stb && ack);
  cover property (stb && ack && we && tgc == blk_bus_pkg::CK_RMW);
endmodule // blk_bus_asserts

/* tb/tb_block_and_rmw_bus_cycles.sv */
// Self-checking bench joining master and slave ends over one bus
`timescale 1ns/100ps
module tb_block_and_rmw_bus_cycles;
  logic             clock_i, arst_n_i;
  logic             cmd_valid, cmd_lock, pause, wr_valid, stall;
  logic             cmd_ready, wr_ready, rd_valid, done, busy;
  logic             lock_held, rmw_done, rmw_abort;
  blk_bus_pkg::op_t cmd_op;
  logic [7:0]       cmd_len;
  logic [31:0]      cmd_addr, wr_data, rd_data;
  logic [3:0]       cmd_tga, cmd_sel, wr_tgd, wr_sel, rd_tgd;
  logic [1:0]       cycle_kind;
  logic [31:0]      ref_mem [64];
  logic [3:0]       last_tgd = 4'h0;
  int               err_total = 0;
  int               checks_done = 0;

  blk_bus_if i_blk_bus_if ();

  blk_bus_master i_blk_bus_master (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .bus(i_blk_bus_if),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_len_i(cmd_len),
    .cmd_addr_i(cmd_addr), .cmd_tga_i(cmd_tga), .cmd_sel_i(cmd_sel),
    .cmd_lock_i(cmd_lock), .cmd_ready_o(cmd_ready), .pause_i(pause),
    .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_tgd_i(wr_tgd),
    .wr_sel_i(wr_sel), .wr_ready_o(wr_ready), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .rd_tgd_o(rd_tgd), .done_o(done), .busy_o(busy));

  blk_bus_slave i_blk_bus_slave (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .bus(i_blk_bus_if),
    .stall_i(stall), .lock_held_o(lock_held), .cycle_kind_o(cycle_kind),
    .rmw_done_o(rmw_done), .rmw_abort_o(rmw_abort));

  blk_bus_asserts i_blk_bus_asserts (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .cyc(i_blk_bus_if.cyc),
    .stb(i_blk_bus_if.stb), .lock(i_blk_bus_if.lock),
    .we(i_blk_bus_if.we), .adr(i_blk_bus_if.adr), .tgc(i_blk_bus_if.tgc),
    .ack(i_blk_bus_if.ack));

  // ==========================================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Byte-lane merge as the slave stores a write phase
  function automatic logic [31:0] merge(logic [31:0] old, nw,
                                        logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) old[8*b +: 8] = nw[8*b +: 8];
    end
    return old;
  endfunction

  // Word index wraps inside the slave's depth
  function automatic logic [5:0] widx(logic [31:0] a, int i);
    return a[7:2] + 6'(i);
  endfunction

  // One command; slow turns on random master and slave wait states
  task automatic run(input blk_bus_pkg::op_t op, input int len,
                     input logic [31:0] adr, input logic lk, input bit slow);
    int   n_cyc, n_ack, n_rd, n_wr, n_rmw, n_abt, t;
    bit   go, took, rmw, rd_op, wr_op;
    logic [5:0] a;
    n_cyc = 0; n_ack = 0; n_rd = 0; n_wr = 0; n_rmw = 0;
    n_abt = 0;
    go = 0; took = 0; rmw = (op == blk_bus_pkg::OP_RMW);
    rd_op = (op == blk_bus_pkg::OP_READ);
    wr_op = (op == blk_bus_pkg::OP_WRITE);
    for (t = 0; t < 400; t++) begin
      @(negedge clock_i);
      cmd_valid = !go;
      cmd_op = op; cmd_len = 8'(len); cmd_addr = adr; cmd_lock = lk;
      if (t == 0) {cmd_tga, cmd_sel} = 8'($urandom);
      pause = slow && $urandom_range(2) == 0;
      stall = slow && $urandom_range(2) == 0;
      // An offered word stays put until the master takes it
      if (took || !wr_valid) begin
        wr_valid = !slow || $urandom_range(1) == 1;
        {wr_sel, wr_tgd} = 8'($urandom);
        wr_data = $urandom;
      end
      #9;
      took = (wr_ready === 1'b1);
      if (cmd_ready === 1'b1) go = 1;
      if (i_blk_bus_if.cyc === 1'b1) begin
        n_cyc++;
        check("lock", 32'(i_blk_bus_if.lock), 32'(lk));
      end
      if ((i_blk_bus_if.stb & i_blk_bus_if.ack) === 1'b1) n_ack++;
      // Read checked first: the write half lands after it
      if (rd_valid === 1'b1) begin
        check("read data", rd_data, ref_mem[widx(adr, n_rd)]);
        check("read tag", 32'(rd_tgd), 32'(last_tgd));
        n_rd++;
      end
      // Slave keeps one data tag: the last written one
      if (took) begin
        a = widx(adr, rmw ? 0 : n_wr);
        ref_mem[a] = merge(ref_mem[a], wr_data, wr_sel);
        last_tgd = wr_tgd;
        n_wr++;
      end
      if (rmw_done === 1'b1) n_rmw++;
      if (rmw_abort === 1'b1) n_abt++;
      if (done === 1'b1) break;
    end
    if (t == 400) begin
      err_total++;
      results();
    end
    check("acks", n_ack, rmw ? 2 : len);
    check("writes", n_wr, rd_op ? 0 : rmw ? 1 : len);
    check("reads", n_rd, wr_op ? 0 : rmw ? 1 : len);
    check("kind", 32'(cycle_kind), rmw ? 32'(blk_bus_pkg::CK_RMW)
                                 : len < 2 ? 32'(blk_bus_pkg::CK_SINGLE)
                                 : 32'(blk_bus_pkg::CK_BLOCK));
    check("rmw done", n_rmw, 32'(rmw));
    check("rmw abort", n_abt, 32'h0000_0000);
    check("busy", 32'(busy), 32'h0000_0000);
    check("lock held", 32'(lock_held), 32'(lk));
    if (!slow) check("cycle length", n_cyc, rmw ? 3 : len);
    $display("test %s len %0d slow %0d ended", op.name(), len, slow);
  endtask

  // ==========================================================================
  // Clock and sequence
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  initial begin
    arst_n_i = 1'b0;
    {cmd_valid, cmd_lock, pause, wr_valid, stall} = 5'h00;
    cmd_op = blk_bus_pkg::OP_READ;
    cmd_len = 8'h00;
    {cmd_addr, wr_data} = 64'h0000_0000_0000_0000;
    {cmd_tga, cmd_sel, wr_tgd, wr_sel} = 16'h0000;
    foreach (ref_mem[i]) ref_mem[i] = 32'h0000_0000;
    void'($urandom(32'h46e3_6c8c));
    repeat (4) @(negedge clock_i);
    arst_n_i = 1'b1;
    // Back-to-back phases across the top of the memory, then an RMW on its last word
    run(blk_bus_pkg::OP_WRITE, 6, 32'h0000_00f8, 1'b1, 1'b0);
    run(blk_bus_pkg::OP_READ, 6, 32'h0000_00f8, 1'b0, 1'b0);
    run(blk_bus_pkg::OP_RMW, 1, 32'h0000_00fc, 1'b1, 1'b0);
    // One phase only: runs as a single cycle; then a slow two-phase read across the top
    run(blk_bus_pkg::OP_WRITE, 1, 32'h0000_0040, 1'b0, 1'b0);
    run(blk_bus_pkg::OP_READ, 2, 32'h0000_00fc, 1'b1, 1'b1);
    repeat (16) begin
      run(blk_bus_pkg::op_t'($urandom_range(2)), $urandom_range(6, 2),
          $urandom & 32'h0000_00fc, 1'($urandom), 1'b1);
    end
    results();
  end
endmodule // tb_block_and_rmw_bus_cycles
